// ---- verification/asz_codec_model.sv ----
// codec side model: measures the master clock it receives
`timescale 1ns/1ps
module asz_codec_model (
	// clocks
	input wire logic clk_sys,
	input wire logic codecClk,
	// rising-edge spacing in system clocks
	output logic [7:0] period = 8'h00
);
	logic last = 1'b0;
	logic [7:0] cnt = 8'h00;
	// a codec only cares about edge spacing, not phase to clk_sys
	always @(posedge clk_sys) begin
		last <= codecClk;
		cnt <= (codecClk && !last) ? 8'h01 : cnt + 8'h01;
		if (codecClk && !last) begin
			period <= cnt;
		end
	end
endmodule : asz_codec_model

// ---- verification/tb_top.sv ----
// testbench of the audio port control block
`timescale 1ns/1ps
`include "asz_params.svh"
module tb_top;
	import asz_pkg::*;
	logic clk_sys = 1'b0, nrst = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, codecClk, rxThresholdFlag, txThresholdFlag, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	asz_word_t leftSample = '0, rightSample = '0;
	logic leftLoad = 1'b0, rightLoad = 1'b0;
	asz_lvl_t rxLevel = '0, txLevel = '0;
	logic [7:0] period;
	logic [15:0] rnd = 16'h002C;
	int errorCnt = 0, numChecks = 0;

	asz_top dut (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .leftSample, .leftLoad,
		.rightSample, .rightLoad, .rxLevel, .txLevel, .codecClk,
		.rxThresholdFlag, .txThresholdFlag, .irq);
	asz_codec_model codec (.clk_sys, .codecClk, .period);

	initial forever #4 clk_sys = ~clk_sys;

	// --------
	// helpers
	// --------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// expected flags and sign bit, from the field meanings
	function automatic logic expRx(input int lv, input int th);
		return lv >= th + 1;
	endfunction : expRx

	function automatic logic expTx(input int lv, input int th);
		return lv <= th;
	endfunction : expTx

	function automatic logic signAt(input logic [31:0] v,
		input logic [1:0] ww);
		return v[8 * ww + 7];
	endfunction : signAt

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[ERR] %0t seen %08h expected %08h", $time, seen, exp);
		end
	endtask : chk

	task automatic closeOut;
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : closeOut

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_awready || !s_axi_awvalid)
			|| !(s_axi_wready || !s_axi_wvalid));
		do @(posedge clk_sys); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk_sys);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// one load strobe on the chosen channel, sample on both buses
	task automatic ld(input logic ch, input asz_word_t s);
		@(posedge clk_sys);
		leftSample <= s;
		rightSample <= s;
		leftLoad <= !ch;
		rightLoad <= ch;
		@(posedge clk_sys);
		leftLoad <= 1'b0;
		rightLoad <= 1'b0;
	endtask : ld

	// --------
	// main sequence
	// --------
	initial begin
		logic [31:0] d, s;
		logic [1:0] r, w, m, e, prv;
		logic [2:0] tt;
		logic [3:0] tl;
		logic ch, en, sg;
		prv = 2'b00;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(12'(i * 4), d, r);
			chk(d, 32'h0000_0000);
		end
		rd(12'h010, d, r);
		chk(d, 32'h0000_0000);
		chk(32'(r), 32'(`ASZ_RESP_SLVERR));
		wr(12'h010, 32'hFFFF_FFFF, r);
		chk(32'(r), 32'(`ASZ_RESP_SLVERR));
		wr(`ASZ_OFF_CTRL, 32'hFFFF_FFFF, r);
		rd(`ASZ_OFF_CTRL, d, r);
		chk(d, `ASZ_CTRL_WMASK & ~`ASZ_CTRL_SELFCLR);
		// only byte one written: bits 15:8 go to zero, the rest stay
		s_axi_wstrb <= 4'h2;
		wr(`ASZ_OFF_CTRL, 32'h0000_0000, r);
		s_axi_wstrb <= 4'hF;
		rd(`ASZ_OFF_CTRL, d, r);
		chk(d, 32'h0033_00FF);
		// every rx threshold code against every rx fill level, tx threshold and level random
		for (int th = 0; th < 8; th++) begin
			rnd = lfsr(rnd);
			tt = rnd[2:0];
			wr(`ASZ_OFF_CTRL, (32'(th) << 12) | (32'(tt) << 9)
				| (32'(rnd[5:4]) << 4), r);
			for (int lv = 0; lv < 9; lv++) begin
				rnd = lfsr(rnd);
				tl = 4'(rnd % 9);
				@(posedge clk_sys);
				rxLevel <= 4'(lv);
				txLevel <= tl;
				repeat (2) @(posedge clk_sys);
				chk(32'(rxThresholdFlag), 32'(expRx(lv, th)));
				chk(32'(txThresholdFlag), 32'(expTx(tl, tt)));
			end
		end
		wr(`ASZ_OFF_STATUS, 32'h0000_0003, r);
		// zero cross on random samples, widths and enables
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			{m, w, en, ch} = rnd[5:0];
			s = (i == 5) ? 32'h0000_0000 : {rnd, lfsr(rnd)};
			wr(`ASZ_OFF_CTRL, (32'(en) << (17 - ch)) | (32'(w) << 4), r);
			wr(`ASZ_OFF_MASK, 32'(m), r);
			ld(ch, s);
			sg = signAt(s, w);
			e = 2'b00;
			e[ch] = en && (sg != prv[ch] || s == 32'h0000_0000);
			prv[ch] = sg;
			rd(`ASZ_OFF_STATUS, d, r);
			chk(32'(d[1:0]), 32'(e));
			chk(32'(irq), 32'(|(e & m)));
			wr(`ASZ_OFF_STATUS, 32'h0000_0003, r);
		end
		// codec clock for every divider code
		for (int n = 0; n < 8; n++) begin
			wr(`ASZ_OFF_CLKDIV, 32'(n), r);
			wr(`ASZ_OFF_CTRL, 32'h0000_8000, r);
			repeat (40) @(posedge clk_sys);
			chk(32'(period), 32'(2 * (n == 0 ? 1 : n)));
			wr(`ASZ_OFF_CTRL, 32'h0000_0000, r);
			repeat (2) @(posedge clk_sys);
			chk(32'(codecClk), 32'h0000_0000);
		end
		closeOut();
	end

	// whole run is about a thousand cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		errorCnt++;
		closeOut();
	end
endmodule : tb_top

// ---- verilog/asz_params.svh ----
// register map, field positions and reset values of the audio port control
`ifndef ASZ_PARAMS_SVH
`define ASZ_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASZ_OFF_CTRL 12'h000
`define ASZ_OFF_CLKDIV 12'h004
`define ASZ_OFF_MASK 12'h008
`define ASZ_OFF_STATUS 12'h00C

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ASZ_CTRL_LZC_BIT 17
`define ASZ_CTRL_RZC_BIT 16
`define ASZ_CTRL_MCLK_BIT 15
`define ASZ_CTRL_RX_FILL_THRESHOLD_HI 14
`define ASZ_CTRL_RX_FILL_THRESHOLD_LO 12
`define ASZ_CTRL_TX_FILL_THRESHOLD_HI 11
`define ASZ_CTRL_TX_FILL_THRESHOLD_LO 9
`define ASZ_CTRL_WW_HI 5
`define ASZ_CTRL_WW_LO 4
`define ASZ_CTRL_WMASK 32'h003F_FFFF
`define ASZ_CTRL_SELFCLR 32'h000C_0000
`define ASZ_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------
// divider, status and mask fields
// ----------------------------------------------------------------
`define ASZ_DIV_HI 2
`define ASZ_DIV_RESET 3'h0
`define ASZ_ST_LZC 0
`define ASZ_ST_RZC 1
`define ASZ_ST_RX_FILL_THRESHOLD 2
`define ASZ_ST_TX_FILL_THRESHOLD 3
`define ASZ_ST_W 4
`define ASZ_ST_RESET 4'h0
`define ASZ_MASK_RESET 4'h0

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define ASZ_RESP_OKAY 2'h0
`define ASZ_RESP_SLVERR 2'h2

`endif

// ---- verilog/asz_pkg.sv ----
// types shared by the audio port control block
package asz_pkg;
	typedef logic [3:0] asz_lvl_t;
	typedef logic [31:0] asz_word_t;
	typedef enum logic [1:0] {
		ASZ_W8,
		ASZ_W16,
		ASZ_W24,
		ASZ_W32
	} asz_width_e;
endpackage : asz_pkg

// ---- verilog/asz_top.sv ----
// audio port control: zero cross, codec clock, fifo thresholds, axi regs
`timescale 1ns/1ps
`include "asz_params.svh"

module asz_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// samples from the shifters and fifo levels
	input wire asz_pkg::asz_word_t leftSample,
	input wire logic leftLoad,
	input wire asz_pkg::asz_word_t rightSample,
	input wire logic rightLoad,
	input wire asz_pkg::asz_lvl_t rxLevel,
	input wire asz_pkg::asz_lvl_t txLevel,
	// outputs
	output logic codecClk,
	output logic rxThresholdFlag,
	output logic txThresholdFlag,
	output logic irq
);
	import asz_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic signOf(asz_word_t d, asz_width_e w);
		case (w)
			ASZ_W8: signOf = d[7];
			ASZ_W16: signOf = d[15];
			ASZ_W24: signOf = d[23];
			default: signOf = d[31];
		endcase
	endfunction : signOf

	function automatic logic [31:0] mergeBytes(logic [31:0] old,
			logic [31:0] d, logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		mergeBytes = r;
	endfunction : mergeBytes

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [`ASZ_DIV_HI:0] clkDiv;
	logic [`ASZ_ST_W-1:0] mask;
	logic [1:0] zcSticky;
	logic leftSign;
	logic rightSign;
	logic [2:0] mclkCnt;

	// ----------------------------------------------------------------
	// axi write path
	// ----------------------------------------------------------------
	logic awHeld;
	logic wHeld;
	logic [11:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;

	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire haveAw = awHeld || awTake;
	wire haveW = wHeld || wTake;
	wire [11:0] curAw = awHeld ? awAddr : s_axi_awaddr;
	wire [31:0] curW = wHeld ? wData : s_axi_wdata;
	wire [3:0] curS = wHeld ? wStrb : s_axi_wstrb;
	wire doWrite = haveAw && haveW && !s_axi_bvalid;
	wire wrCtrl = doWrite && curAw == `ASZ_OFF_CTRL;
	wire wrDiv = doWrite && curAw == `ASZ_OFF_CLKDIV;
	wire wrMask = doWrite && curAw == `ASZ_OFF_MASK;
	wire wrStat = doWrite && curAw == `ASZ_OFF_STATUS;
	wire wrHit = wrCtrl || wrDiv || wrMask || wrStat;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 12'h000;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ASZ_RESP_OKAY;
		end else begin
			if (awTake) begin
				awAddr <= s_axi_awaddr;
			end
			if (wTake) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			awHeld <= haveAw && !doWrite;
			wHeld <= haveW && !doWrite;
			s_axi_awready <= !(haveAw && !doWrite) && !doWrite;
			s_axi_wready <= !(haveW && !doWrite) && !doWrite;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? `ASZ_RESP_OKAY : `ASZ_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control, divider and mask
	// ----------------------------------------------------------------
	// fifo clear bits are one-shot and never stored, so they read zero
	wire [31:0] ctrlNew = mergeBytes(ctrl, curW, curS) & `ASZ_CTRL_WMASK
		& ~`ASZ_CTRL_SELFCLR;
	wire [31:0] divNew = mergeBytes({29'h0, clkDiv}, curW, curS);
	wire [31:0] maskNew = mergeBytes({28'h0, mask}, curW, curS);

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl <= `ASZ_CTRL_RESET;
			clkDiv <= `ASZ_DIV_RESET;
			mask <= `ASZ_MASK_RESET;
		end else begin
			if (wrCtrl) begin
				ctrl <= ctrlNew;
			end
			if (wrDiv) begin
				clkDiv <= divNew[`ASZ_DIV_HI:0];
			end
			if (wrMask) begin
				mask <= maskNew[`ASZ_ST_W-1:0];
			end
		end
	end

	wire lzcEn = ctrl[`ASZ_CTRL_LZC_BIT];
	wire rzcEn = ctrl[`ASZ_CTRL_RZC_BIT];
	wire codec_clock_out_enable = ctrl[`ASZ_CTRL_MCLK_BIT];
	wire [2:0] rx_fill_threshold = ctrl[`ASZ_CTRL_RX_FILL_THRESHOLD_HI:`ASZ_CTRL_RX_FILL_THRESHOLD_LO];
	wire [2:0] tx_fill_threshold = ctrl[`ASZ_CTRL_TX_FILL_THRESHOLD_HI:`ASZ_CTRL_TX_FILL_THRESHOLD_LO];
	wire asz_width_e width =
		asz_width_e'(ctrl[`ASZ_CTRL_WW_HI:`ASZ_CTRL_WW_LO]);

	// ----------------------------------------------------------------
	// zero-cross detection
	// ----------------------------------------------------------------
	wire leftNewSign = signOf(leftSample, width);
	wire rightNewSign = signOf(rightSample, width);
	wire leftHit = lzcEn && leftLoad
		&& (leftNewSign != leftSign || leftSample == 32'h0000_0000);
	wire rightHit = rzcEn && rightLoad
		&& (rightNewSign != rightSign || rightSample == 32'h0000_0000);
	// write-one clears, but a detection in the same cycle wins
	wire [1:0] zcClr = wrStat ? curW[1:0] & {curS[0], curS[0]} : 2'h0;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			leftSign <= 1'b0;
			rightSign <= 1'b0;
			zcSticky <= 2'h0;
		end else begin
			if (leftLoad) begin
				leftSign <= leftNewSign;
			end
			if (rightLoad) begin
				rightSign <= rightNewSign;
			end
			zcSticky <= (zcSticky & ~zcClr) | {rightHit, leftHit};
		end
	end

	// ----------------------------------------------------------------
	// fifo thresholds
	// ----------------------------------------------------------------
	// tx level arrives as a count of 32-bit entries
	wire rxOver = rxLevel >= ({1'b0, rx_fill_threshold} + 4'h1);
	wire txUnder = txLevel <= {1'b0, tx_fill_threshold};

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rxThresholdFlag <= 1'b0;
			txThresholdFlag <= 1'b0;
		end else begin
			rxThresholdFlag <= rxOver;
			txThresholdFlag <= txUnder;
		end
	end

	// ----------------------------------------------------------------
	// codec clock
	// ----------------------------------------------------------------
	// half period of n source cycles gives source / 2n; 0 acts as 1
	wire [2:0] halfPeriod = clkDiv == 3'h0 ? 3'h1 : clkDiv;
	wire mclkFlip = mclkCnt == halfPeriod - 3'h1;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mclkCnt <= 3'h0;
			codecClk <= 1'b0;
		end else if (!codec_clock_out_enable) begin
			mclkCnt <= 3'h0;
			codecClk <= 1'b0;
		end else if (mclkFlip) begin
			mclkCnt <= 3'h0;
			codecClk <= !codecClk;
		end else begin
			mclkCnt <= mclkCnt + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// status and interrupt
	// ----------------------------------------------------------------
	wire [`ASZ_ST_W-1:0] status = {txThresholdFlag, rxThresholdFlag,
		zcSticky};

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// ----------------------------------------------------------------
	// axi read path
	// ----------------------------------------------------------------
	wire arTake = s_axi_arvalid && s_axi_arready;
	wire rdCtrl = s_axi_araddr == `ASZ_OFF_CTRL;
	wire rdDiv = s_axi_araddr == `ASZ_OFF_CLKDIV;
	wire rdMask = s_axi_araddr == `ASZ_OFF_MASK;
	wire rdStat = s_axi_araddr == `ASZ_OFF_STATUS;
	wire rdHit = rdCtrl || rdDiv || rdMask || rdStat;
	wire [31:0] rdMux = rdCtrl ? ctrl
		: rdDiv ? {29'h0, clkDiv}
		: rdMask ? {28'h0, mask}
		: rdStat ? {28'h0, status} : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ASZ_RESP_OKAY;
		end else begin
			s_axi_arready <= !arTake && !s_axi_rvalid;
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdHit ? `ASZ_RESP_OKAY : `ASZ_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence leftEvent;
		lzcEn && leftHit;
	endsequence

	sequence leftSeen;
		##1 zcSticky[0];
	endsequence

	a_left_zc_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		leftEvent |-> leftSeen)
		else $error("left zero-cross flag not set");

	a_left_zc_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		!lzcEn && !zcSticky[0] |=> !zcSticky[0])
		else $error("left flag set while detection off");

	a_right_zc_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		rzcEn && rightLoad && rightSample == 32'h0000_0000
		|=> zcSticky[1])
		else $error("right zero-cross flag not set");

	a_clk_stopped: assert property (@(posedge clk_sys) disable iff (!nrst)
		!codec_clock_out_enable |=> !codecClk)
		else $error("codec clock runs while disabled");

	a_clk_half: assert property (@(posedge clk_sys) disable iff (!nrst)
		codec_clock_out_enable && clkDiv == 3'h3 && $stable(clkDiv) && $rose(codecClk)
		&& $past(codec_clock_out_enable, 4)
		|-> ##2 (codecClk || !codec_clock_out_enable) ##1 !codecClk)
		else $error("codec clock half period wrong");

	a_rx_thresh: assert property (@(posedge clk_sys) disable iff (!nrst)
		rxLevel > {1'b0, rx_fill_threshold} |=> rxThresholdFlag)
		else $error("rx threshold flag missing");

	a_tx_thresh: assert property (@(posedge clk_sys) disable iff (!nrst)
		txLevel <= {1'b0, tx_fill_threshold} |=> txThresholdFlag)
		else $error("tx threshold flag missing");

	a_flag_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
		txLevel > {1'b0, tx_fill_threshold} && rxLevel <= {1'b0, rx_fill_threshold}
		|=> !txThresholdFlag && !rxThresholdFlag)
		else $error("threshold flag held after condition ended");

	a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
		(status & mask) != 4'h0 |=> irq)
		else $error("interrupt not raised");

endmodule : asz_top
